// ---- logic/vop_port.sv ----
// voice serial port: frame timing, sample shifters and domain crossings
// Function
// - port runs on bit clock while present
// - every sample is a 16-bit serial word
// - out frame pulse one bit period, rising edge
// - sample shifted out in next 16 cycles
// - new out frame every 125 us average
// - frame rate network-locked, jitter one bit period
module vop_port
   import vop_pkg::*;
(
   input  wire logic                clk,                    // network-locked system clock
   input  wire logic                arst_n,                 // asynchronous reset, active low
   input  wire logic                serial_bit_clock_alias, // bit clock from the host
   input  wire logic [SAMPLE_W-1:0] tx_sample,              // next outgoing sample
   output logic                     tx_taken,               // pulse: tx_sample captured
   output logic [SAMPLE_W-1:0]      rx_sample,              // last received sample
   output logic                     rx_valid,               // pulse: rx_sample updated
   output logic                     bit_clock_present,      // bit clock seen recently
   output logic                     voice_out_data,         // outgoing serial data
   output logic                     voice_out_frame_pulse,  // outgoing frame pulse
   input  wire logic                voice_in_data,          // incoming serial data
   input  wire logic                voice_in_frame_pulse    // incoming frame pulse
);

   // ************************************************************
   // system domain state
   // ************************************************************
   typedef struct packed {
      logic [SAMPLE_W-1:0]   tx_hold;    // sample held for the link side
      logic                  frame_tog;  // toggles once per frame
      logic                  rx_seen;    // last rx toggle taken
      logic [SAMPLE_W-1:0]   rx_word;    // captured incoming sample
      logic                  rx_valid;   // capture pulse
      logic                  tx_taken;   // frame pulse to the user
      logic                  alive_seen; // last activity level taken
      logic [IDLE_CNT_W-1:0] idle_cnt;   // cycles without bit clock activity
      logic                  present;    // bit clock present flag
   } vop_sys_s;

   // ************************************************************
   // link domain state, rising edge side
   // ************************************************************
   typedef struct packed {
      vop_tx_state_e       state;      // shifter state
      logic                tog_seen;   // last frame toggle taken
      logic [SAMPLE_W-1:0] shift;      // outgoing shift register
      logic [BITCNT_W-1:0] cnt;        // bits still to send
      logic                frame;      // out frame pulse
      logic                data;       // out data bit
      logic                alive;      // toggles each bit clock
   } vop_tx_s;

   // ************************************************************
   // link domain state, falling edge side
   // ************************************************************
   typedef struct packed {
      logic                busy;       // word reception in progress
      logic [BITCNT_W-1:0] cnt;        // bits already taken
      logic [SAMPLE_W-1:0] shift;      // incoming shift register
      logic [SAMPLE_W-1:0] word;       // completed word, stable for crossing
      logic                tog;        // toggles once per completed word
   } vop_rx_s;

   vop_sys_s sys_r;                    // registered system state
   vop_sys_s sys_nxt;                  // next system state
   vop_tx_s  tx_r;                     // registered rising edge state
   vop_tx_s  tx_nxt;                   // next rising edge state
   vop_rx_s  rx_r;                     // registered falling edge state
   vop_rx_s  rx_nxt;                   // next falling edge state

   logic     frame_tick;               // frame period pulse
   logic     frame_tog_l;              // frame toggle in the link domain
   logic     rx_tog_s;                 // rx toggle in the system domain
   logic     alive_s;                  // activity level in the system domain

   // ************************************************************
   // frame timer and crossings
   // ************************************************************

   // network-locked 8 kHz frame tick
   vop_frame_timer u_timer (
      .clk    (clk),
      .arst_n (arst_n),
      .tick   (frame_tick)
   );

   // frame event to the link, toggle across
   vop_sync u_sync_frame (
      .clk    (serial_bit_clock_alias),
      .arst_n (arst_n),
      .d      (sys_r.frame_tog),
      .q      (frame_tog_l)
   );

   // received word event to the system side
   vop_sync u_sync_rx (
      .clk    (clk),
      .arst_n (arst_n),
      .d      (rx_r.tog),
      .q      (rx_tog_s)
   );

   // bit clock activity to the system side
   vop_sync u_sync_alive (
      .clk    (clk),
      .arst_n (arst_n),
      .d      (tx_r.alive),
      .q      (alive_s)
   );

   // ************************************************************
   // system domain logic
   // ************************************************************

   // sample handover, rx capture and clock watchdog
   always_comb begin
      sys_nxt          = sys_r;
      sys_nxt.rx_valid = 1'b0;
      sys_nxt.tx_taken = 1'b0;
      // frame start: latch the user sample and signal the link
      if (frame_tick) begin
         sys_nxt.tx_hold   = tx_sample;
         sys_nxt.frame_tog = ~sys_r.frame_tog;
         sys_nxt.tx_taken  = 1'b1;
      end
      // completed word from the link, stable while toggle settles
      if (rx_tog_s != sys_r.rx_seen) begin
         sys_nxt.rx_seen  = rx_tog_s;
         sys_nxt.rx_word  = rx_r.word;
         sys_nxt.rx_valid = 1'b1;
      end
      // any bit clock activity restarts the watchdog
      if (alive_s != sys_r.alive_seen) begin
         sys_nxt.alive_seen = alive_s;
         sys_nxt.idle_cnt   = '0;
         sys_nxt.present    = 1'b1;
      end else if (sys_r.idle_cnt == IDLE_LAST) begin
         // clock gone for two slowest periods
         sys_nxt.present = 1'b0;
      end else begin
         sys_nxt.idle_cnt = sys_r.idle_cnt + 8'h01;
      end
   end

   // register the system state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sys_r <= '0;
      end else begin
         sys_r <= sys_nxt;
      end
   end

   // ************************************************************
   // link domain, outgoing side on rising edges
   // ************************************************************

   // frame pulse then sixteen data bits, msb first
   always_comb begin
      tx_nxt       = tx_r;
      tx_nxt.alive = ~tx_r.alive;
      tx_nxt.frame = 1'b0;
      unique case (tx_r.state)
         VOP_TX_IDLE: begin
            tx_nxt.data = 1'b0;
         end
         VOP_TX_FRAME: begin
            // first bit follows the frame pulse
            tx_nxt.data  = tx_r.shift[SAMPLE_W-1];
            tx_nxt.shift = {tx_r.shift[SAMPLE_W-2:0], 1'b0};
            tx_nxt.cnt   = BITS_M1;
            tx_nxt.state = VOP_TX_SHIFT;
         end
         VOP_TX_SHIFT: begin
            if (tx_r.cnt == '0) begin
               // all sixteen bits sent
               tx_nxt.data  = 1'b0;
               tx_nxt.state = VOP_TX_IDLE;
            end else begin
               tx_nxt.data  = tx_r.shift[SAMPLE_W-1];
               tx_nxt.shift = {tx_r.shift[SAMPLE_W-2:0], 1'b0};
               tx_nxt.cnt   = tx_r.cnt - 4'h1;
            end
         end
         default: begin
            // illegal code, back to idle
            tx_nxt.data  = 1'b0;
            tx_nxt.state = VOP_TX_IDLE;
         end
      endcase
      // new frame event wins over any leftover activity
      if (frame_tog_l != tx_r.tog_seen) begin
         tx_nxt.tog_seen = frame_tog_l;
         tx_nxt.shift    = sys_r.tx_hold;
         tx_nxt.frame    = 1'b1;
         tx_nxt.data     = 1'b0;
         tx_nxt.state    = VOP_TX_FRAME;
      end
   end

   // rising edge registers, clocked only by the host bit clock
   always_ff @(posedge serial_bit_clock_alias or negedge arst_n) begin
      if (!arst_n) begin
         tx_r <= '{state: VOP_TX_IDLE, default: '0};
      end else begin
         tx_r <= tx_nxt;
      end
   end

   // ************************************************************
   // link domain, incoming side on falling edges
   // ************************************************************

   // frame pulse arms, then sixteen bits msb first
   always_comb begin
      rx_nxt = rx_r;
      if (voice_in_frame_pulse) begin
         rx_nxt.busy = 1'b1;
         rx_nxt.cnt  = '0;
      end else if (rx_r.busy) begin
         rx_nxt.shift = {rx_r.shift[SAMPLE_W-2:0], voice_in_data};
         rx_nxt.cnt   = rx_r.cnt + 4'h1;
         if (rx_r.cnt == BITS_M1) begin
            // final bit in: publish the word
            rx_nxt.busy = 1'b0;
            rx_nxt.word = {rx_r.shift[SAMPLE_W-2:0], voice_in_data};
            rx_nxt.tog  = ~rx_r.tog;
         end
      end
   end

   // falling edge registers
   always_ff @(negedge serial_bit_clock_alias or negedge arst_n) begin
      if (!arst_n) begin
         rx_r <= '0;
      end else begin
         rx_r <= rx_nxt;
      end
   end

   // ************************************************************
   // outputs, all straight from flip-flops
   // ************************************************************
   assign tx_taken              = sys_r.tx_taken;
   assign rx_sample             = sys_r.rx_word;
   assign rx_valid              = sys_r.rx_valid;
   assign bit_clock_present     = sys_r.present;
   assign voice_out_data        = tx_r.data;
   assign voice_out_frame_pulse = tx_r.frame;

   // ************************************************************
   // checks
   // ************************************************************
   logic [FRAME_CNT_W-1:0] gap_cnt;    // cycles since the last frame
   logic                   gap_ok;     // one full gap observed

   // measure spacing between user frame pulses
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gap_cnt <= '0;
         gap_ok  <= 1'b0;
      end else if (sys_r.tx_taken) begin
         gap_cnt <= '0;
         gap_ok  <= 1'b1;
      end else begin
         gap_cnt <= gap_cnt + 11'h001;
      end
   end

   a_frame_period: assert property (
      @(posedge clk) disable iff (!arst_n)
      (sys_r.tx_taken && gap_ok) |-> (gap_cnt == FRAME_LAST))
      else $error("frame spacing wrong");

   a_sample_latch: assert property (
      @(posedge clk) disable iff (!arst_n)
      sys_r.tx_taken |-> (sys_r.tx_hold == $past(tx_sample)) && (sys_r.frame_tog != $past(sys_r.frame_tog)))
      else $error("sample not latched at frame");

   a_clock_loss: assert property (
      @(posedge clk) disable iff (!arst_n)
      (sys_r.idle_cnt == IDLE_LAST && alive_s == sys_r.alive_seen) |=> !bit_clock_present)
      else $error("lost clock not flagged");

   a_frame_single: assert property (
      @(posedge serial_bit_clock_alias) disable iff (!arst_n)
      voice_out_frame_pulse |=> !voice_out_frame_pulse && tx_r.state == VOP_TX_SHIFT)
      else $error("frame pulse not one period");

   a_msb_first: assert property (
      @(posedge serial_bit_clock_alias) disable iff (!arst_n)
      voice_out_frame_pulse |=> voice_out_data == $past(tx_r.shift[SAMPLE_W-1]))
      else $error("first bit not msb");

   a_shift_length: assert property (
      @(posedge serial_bit_clock_alias) disable iff (!arst_n)
      (voice_out_frame_pulse && frame_tog_l == tx_r.tog_seen)
      |=> (tx_r.state == VOP_TX_SHIFT && tx_r.cnt == BITS_M1)
      ##15 (tx_r.state == VOP_TX_SHIFT && tx_r.cnt == '0)
      ##1 (tx_r.state == VOP_TX_IDLE || voice_out_frame_pulse))
      else $error("sample not sixteen bits");

   a_rx_word: assert property (
      @(negedge serial_bit_clock_alias) disable iff (!arst_n)
      (rx_r.busy && !voice_in_frame_pulse && rx_r.cnt == BITS_M1)
      |=> rx_r.word[0] == $past(voice_in_data) && !rx_r.busy && rx_r.tog != $past(rx_r.tog))
      else $error("received word not published");

   a_rx_deliver: assert property (
      @(posedge clk) disable iff (!arst_n)
      $rose(rx_valid) |-> rx_sample == rx_r.word)
      else $error("delivered word differs");

endmodule

// ---- common/vop_pkg.sv ----
// package of constants and types for the voice serial port
package vop_pkg;

   // ************************************************************
   // sample format
   // ************************************************************
   localparam int unsigned SAMPLE_W   = 16;          // bits per sample, both directions
   localparam int unsigned BITCNT_W   = 4;           // width of the bit counters
   localparam logic [3:0]  BITS_M1    = 4'hF;        // last bit index of a sample
   localparam logic [3:0]  BITCNT_ONE = 4'h1;        // counter value on the final bit

   // ************************************************************
   // system clock and frame timing
   // ************************************************************
   localparam int unsigned SYS_CLK_KHZ   = 10000;    // system clock rate in kHz
   localparam int unsigned SYS_PERIOD_NS = 100;      // system clock period in ns
   localparam int unsigned FRAME_US      = 125;      // mean spacing of out frame pulses
   localparam int unsigned FRAME_CYC     = (FRAME_US * SYS_CLK_KHZ) / 1000;
   localparam int unsigned FRAME_CNT_W   = 11;       // width of the frame timer
   localparam logic [10:0] FRAME_LAST    = 11'(FRAME_CYC - 1);

   // ************************************************************
   // bit clock presence watchdog
   // ************************************************************
   localparam int unsigned BCLK_MIN_KHZ   = 200;     // slowest legal bit clock
   localparam int unsigned BCLK_MAX_NS    = 1000000 / BCLK_MIN_KHZ;
   localparam int unsigned IDLE_CYC       = (2 * BCLK_MAX_NS) / SYS_PERIOD_NS;
   localparam int unsigned IDLE_CNT_W     = 8;       // width of the idle counter
   localparam logic [7:0]  IDLE_LAST      = 8'(IDLE_CYC - 1);

   // ************************************************************
   // outgoing shifter states, gray along idle-frame-shift
   // ************************************************************
   typedef enum logic [1:0] {
      VOP_TX_IDLE  = 2'h0,
      VOP_TX_FRAME = 2'h1,
      VOP_TX_SHIFT = 2'h3
   } vop_tx_state_e;

   // reset values
   localparam logic [15:0] SAMPLE_RST = 16'h0000;    // cleared sample word

endpackage

// ---- logic/vop_sync.sv ----
// two flip-flop level synchroniser
module vop_sync
   import vop_pkg::*;
(
   input  wire logic clk,       // destination clock
   input  wire logic arst_n,    // asynchronous reset, active low
   input  wire logic d,         // level from the other domain
   output logic      q          // synchronised level
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic meta;                // first stage, read only by the second
      logic stab;                // second stage
   } vop_sync_s;

   vop_sync_s s_r;               // registered state
   vop_sync_s s_nxt;             // next state

   // shift the level through both stages
   always_comb begin
      s_nxt.meta = d;
      s_nxt.stab = s_r.meta;
   end

   // register the chain
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.stab;

endmodule

// ---- logic/vop_frame_timer.sv ----
// 8 kHz frame tick generator on the network-locked system clock
module vop_frame_timer
   import vop_pkg::*;
(
   input  wire logic clk,       // network-locked system clock
   input  wire logic arst_n,    // asynchronous reset, active low
   output logic      tick       // one-cycle pulse every frame period
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [FRAME_CNT_W-1:0] cnt;    // cycles into the current frame
      logic                   tick;   // frame pulse
   } vop_tmr_s;

   vop_tmr_s s_r;                     // registered state
   vop_tmr_s s_nxt;                   // next state

   // count the frame period, wrap and pulse
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (s_r.cnt == FRAME_LAST) begin
         // wrap: frame rate follows the system clock, not the bit clock
         s_nxt.cnt  = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 11'h001;
      end
   end

   // register the timer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;

endmodule

// ---- test/vop_host_model.sv ----
// host side model: bit clock source, word sink and word source
module vop_host_model
   import vop_pkg::*;
(
   input  wire logic                run,                    // bit clock enable
   input  wire logic [SAMPLE_W-1:0] host_word,              // word to send back
   input  wire logic [15:0]         host_delay,             // extra bit clocks before reply
   input  wire logic                voice_out_data,         // data from the port
   input  wire logic                voice_out_frame_pulse,  // frame from the port
   output logic                     serial_bit_clock_alias, // bit clock to the port
   output logic                     voice_in_data,          // data to the port
   output logic                     voice_in_frame_pulse,   // frame to the port
   output logic [SAMPLE_W-1:0]      got_word,               // last word heard
   output logic [15:0]              got_cnt,                // words heard
   output logic [15:0]              pulse_len,              // last frame pulse length
   output logic [15:0]              spacing                 // bit clocks between frames
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [SAMPLE_W-1:0] shreg;    // incoming shift register
   logic [SAMPLE_W-1:0] word_l;   // word being sent
   logic [15:0]         bcnt;     // falling edge count
   logic [15:0]         last_at;  // edge count at last frame
   logic [15:0]         hi_cnt;   // frame high length
   logic [15:0]         wait_cnt; // reply delay left
   int                  rxbit;    // bits heard
   int                  txpos;    // bits left to send
   logic                armed;    // listening for bits
   logic                pend;     // reply pending

   // ************************************************************
   // bit clock, stands at 0 while disabled
   // ************************************************************
   initial begin
      {serial_bit_clock_alias, voice_in_data, voice_in_frame_pulse, armed, pend} = '0;
      {got_word, got_cnt, pulse_len, spacing, shreg, word_l, bcnt, last_at, hi_cnt, wait_cnt} = '0;
      rxbit = 0;
      txpos = 0;
   end

   always begin
      #24;
      serial_bit_clock_alias = run ? ~serial_bit_clock_alias : 1'b0;
   end

   // ************************************************************
   // listen on falling edges: frame then 16 bits msb first
   // ************************************************************
   always @(negedge serial_bit_clock_alias) begin
      bcnt = bcnt + 16'h0001;
      if (voice_out_frame_pulse) begin
         hi_cnt = hi_cnt + 16'h0001;
         if (!armed) begin
            spacing = bcnt - last_at;
            last_at = bcnt;
         end
         armed = 1'b1;
         rxbit = 0;
         pend = 1'b1;
         wait_cnt = host_delay;
      end else begin
         if (hi_cnt != 16'h0000) begin
            pulse_len = hi_cnt;
         end
         hi_cnt = 16'h0000;
         if (armed) begin
            shreg = {shreg[14:0], voice_out_data};
            rxbit++;
            if (rxbit == 16) begin
               got_word = shreg;
               got_cnt = got_cnt + 16'h0001;
               armed = 1'b0;
            end
         end
      end
   end

   // ************************************************************
   // reply on rising edges, frame host_delay bit clocks after the end of the port's frame
   // ************************************************************
   always @(posedge serial_bit_clock_alias) begin
      voice_in_frame_pulse = 1'b0;
      if (pend && wait_cnt == 16'h0000) begin
         voice_in_frame_pulse = 1'b1;
         word_l = host_word;
         txpos = 16;
         pend = 1'b0;
      end else if (txpos > 0) begin
         voice_in_data = word_l[txpos-1];
         txpos--;
      end else begin
         // idle line never repeats the last bit
         voice_in_data = ~voice_in_data;
         if (pend) begin
            wait_cnt = wait_cnt - 16'h0001;
         end
      end
   end
endmodule

// ---- test/tb.sv ----
// self-checking bench for the voice serial port
`define VOP_CHECK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
   $display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module tb
   import vop_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                clk;                    // system clock
   logic                arst_n;                 // reset, active low
   logic [SAMPLE_W-1:0] tx_sample;              // word to send
   logic                tx_taken;               // word captured
   logic [SAMPLE_W-1:0] rx_sample;              // word received
   logic                rx_valid;               // word received pulse
   logic                bit_clock_present;      // clock watchdog
   logic                voice_out_data;         // link out data
   logic                voice_out_frame_pulse;  // link out frame
   logic                voice_in_data;          // link in data
   logic                voice_in_frame_pulse;   // link in frame
   logic                serial_bit_clock_alias; // link clock
   logic                run;                    // host clock enable
   logic [15:0]         host_word;              // host reply word
   logic [15:0]         host_delay;             // host reply delay
   logic [15:0]         got_word;               // word seen by host
   logic [15:0]         got_cnt;                // words seen by host
   logic [15:0]         pulse_len;              // frame pulse length
   logic [15:0]         spacing;                // frame spacing
   int                  error_cnt;              // mismatches
   int                  checks_done;            // comparisons
   int                  cyc;                    // cycle counter

   vop_port DUT (.clk(clk), .arst_n(arst_n), .serial_bit_clock_alias(serial_bit_clock_alias),
      .tx_sample(tx_sample), .tx_taken(tx_taken), .rx_sample(rx_sample), .rx_valid(rx_valid),
      .bit_clock_present(bit_clock_present), .voice_out_data(voice_out_data),
      .voice_out_frame_pulse(voice_out_frame_pulse), .voice_in_data(voice_in_data),
      .voice_in_frame_pulse(voice_in_frame_pulse));

   vop_host_model host (.run(run), .host_word(host_word), .host_delay(host_delay),
      .voice_out_data(voice_out_data), .voice_out_frame_pulse(voice_out_frame_pulse),
      .serial_bit_clock_alias(serial_bit_clock_alias), .voice_in_data(voice_in_data),
      .voice_in_frame_pulse(voice_in_frame_pulse), .got_word(got_word), .got_cnt(got_cnt),
      .pulse_len(pulse_len), .spacing(spacing));

   // ************************************************************
   // clock, timeout and closing report
   // ************************************************************
   always #50 clk = ~clk;

   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // about 9 frames of 1250 cycles are needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         complete_run();
      end
   end

   // wait for tx_taken (sel 0) or rx_valid (sel 1), bounded
   task automatic wait_flag(input int sel, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (((sel == 0) ? tx_taken : rx_valid) !== 1'b1 && n < 3000);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      `VOP_CHECK("presence in reset", 1'b0, bit_clock_present)
      `VOP_CHECK("frame in reset", 1'b0, voice_out_frame_pulse)
      $display("test reset done");
   endtask

   task automatic t_present();
      int n;
      run = 1'b1;
      n = 0;
      while (bit_clock_present !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      `VOP_CHECK("presence", 1'b1, bit_clock_present)
      $display("test present done");
   endtask

   task automatic t_frame_rate();
      int n;
      wait_flag(0, n);
      wait_flag(0, n);
      `VOP_CHECK("frame period", 1250, n)
      repeat (20) @(negedge clk);
      `VOP_CHECK("frame spacing", 1'b1, spacing >= 16'h0A2B && spacing <= 16'h0A2E)
      `VOP_CHECK("pulse length", 16'h0001, pulse_len)
      $display("test frame rate done");
   endtask

   task automatic t_tx_words();
      logic [15:0] w [4] = '{16'hA5C3, 16'h8001, 16'hFFFF, 16'h0000};
      int          n;
      logic [15:0] c;
      for (int i = 0; i < 4; i++) begin
         tx_sample = w[i];
         wait_flag(0, n);
         c = got_cnt;
         n = 0;
         while (got_cnt === c && n < 100) begin
            @(negedge clk);
            n++;
         end
         `VOP_CHECK("word on wire", w[i], got_word)
      end
      $display("test tx words done");
   endtask

   task automatic t_rx_word(input logic [15:0] word, input logic [15:0] dly);
      int n;
      host_word = word;
      host_delay = dly;
      wait_flag(0, n);
      wait_flag(1, n);
      `VOP_CHECK("rx within frame", 1'b1, n < 1000)
      `VOP_CHECK("rx word", word, rx_sample)
      $display("test rx word done");
   endtask

   task automatic t_clock_stop();
      int n;
      host_delay = 16'h0000;
      host_word = 16'h5AA5;
      run = 1'b0;
      repeat (150) @(negedge clk);
      `VOP_CHECK("presence stopped", 1'b0, bit_clock_present)
      run = 1'b1;
      repeat (20) @(negedge clk);
      `VOP_CHECK("presence restarted", 1'b1, bit_clock_present)
      wait_flag(0, n);
      wait_flag(1, n);
      `VOP_CHECK("rx after restart", 16'h5AA5, rx_sample)
      $display("test clock stop done");
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      tx_sample = SAMPLE_RST;
      run = 1'b0;
      host_word = 16'h0000;
      host_delay = 16'h0000;
      error_cnt = 0;
      checks_done = 0;
      cyc = 0;
      repeat (3) @(negedge clk);
      t_reset();
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      t_present();
      t_frame_rate();
      t_tx_words();
      t_rx_word(16'hC3A5, 16'h0000);
      t_rx_word(16'h7FFE, 16'h05DC);
      t_clock_stop();
      complete_run();
   end
endmodule
